// file: bench/tvae_engine_tb_top.sv
// Testbench for the velocity and arc engine
`timescale 1ns/1ps
module tvae_engine_tb_top;
    localparam int TICK = 64;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, sv, busy;
    logic [31:0] wdata, rdata, rv, xs;
    logic [1:0] rresp, rr;
    logic [4:0] prof;
    logic signed [31:0] dx, dy;
    int num_errors = 0, n_checks = 0, cyc = 0, last = 0, sx = 0, sy = 0;
    always #10 clk = ~clk;
    tvae_engine #(.TICK_CYCLES(TICK)) dut_u (.clock_in(clk), .rst_n_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .x_axis_speed_out(xs),
        .y_axis_speed_out(), .vector_speed_out(), .accel_profile_out(prof), .arc_busy_out(busy),
        .step_dx_out(dx), .step_dy_out(dy), .step_valid_out(sv));
    tvae_host host_u (.clock_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid), .bready_out(bready),
        .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
        .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        host_u.rd(a, rv, rr);
        check(what, rv, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sv) begin
            sx <= sx + dx;
            sy <= sy + dy;
            last <= cyc;
            if (last != 0) check("tick gap", 32'(cyc - last), 32'(TICK));
        end
        if (cyc > 20000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("x reset", tvae_pkg::OFS_X_VEL, 32'h0001_0000);
        host_u.wr(tvae_pkg::OFS_VBASE_IN, 32'h0000_0708);
        host_u.wr(tvae_pkg::OFS_VECTOR_TOP_SPEED_IN, 32'h0000_ea60);
        host_u.wr(tvae_pkg::OFS_VCMD, 32'h0000_000c);
        rd_chk("x hex", tvae_pkg::OFS_X_VEL, 32'hea60_0708);
        check("busy", {31'h0, busy}, 32'h0);
        host_u.wr(tvae_pkg::OFS_VBASE_IN, 32'h0000_07d0);
        host_u.wr(tvae_pkg::OFS_VCMD, 32'h0000_0004);
        rd_chk("x base only", tvae_pkg::OFS_X_VEL, 32'hea60_07d0);
        host_u.wr(tvae_pkg::OFS_VECTOR_TOP_SPEED_IN, 32'h000d_0554);
        host_u.wr(tvae_pkg::OFS_VCMD, 32'h0000_0018);
        rd_chk("x decimal", tvae_pkg::OFS_X_VEL, 32'h3415_07d0);
        host_u.wr(tvae_pkg::OFS_VECTOR_TOP_SPEED_IN, 32'h0000_0000);
        host_u.wr(tvae_pkg::OFS_VCMD, 32'h0000_0008);
        rd_chk("x zero max", tvae_pkg::OFS_X_VEL, 32'h3415_07d0);
        rd_chk("status", tvae_pkg::OFS_STATUS, 32'h0000_0002);
        host_u.wr(tvae_pkg::OFS_VBASE_IN, 32'h0000_03e8);
        host_u.wr(tvae_pkg::OFS_VECTOR_TOP_SPEED_IN, 32'h0000_1b58);
        host_u.wr(tvae_pkg::OFS_VCMD, 32'h0000_000e);
        rd_chk("vector", tvae_pkg::OFS_V_VEL, 32'h1b58_03e8);
        rd_chk("x kept", tvae_pkg::OFS_X_VEL, 32'h3415_07d0);
        check("x port", xs, 32'h3415_07d0);
        host_u.rd(8'hfc, rv, rr);
        check("unmapped", {30'h0, rr}, 32'h0000_0002);
        $display("test velocity done");
        host_u.wr(tvae_pkg::OFS_PROFILE, 32'h0000_0003);
        host_u.wr(tvae_pkg::OFS_ARC_RAD, 32'h0100_0001);
        host_u.wr(tvae_pkg::OFS_ARC_LEN, 32'h0000_0028);
        host_u.wr(tvae_pkg::OFS_END_X, 32'h0000_0028);
        host_u.wr(tvae_pkg::OFS_END_Y, 32'h0000_0000);
        host_u.wr(tvae_pkg::OFS_ARC_CTRL, 32'h7fff_0001);
        check("ramp", {27'h0, prof}, 32'h0000_0000);
        wait (busy === 1'b0);
        repeat (2) @(posedge clk);
        check("sum x", sx, 32'h0000_0028);
        check("sum y", sy, 32'h0000_0000);
        rd_chk("profile", tvae_pkg::OFS_PROFILE, 32'h0000_0003);
        rd_chk("straight flag", tvae_pkg::OFS_STATUS, 32'h0000_0008);
        $display("test straight move done");
        stop_test();
    end
endmodule // tvae_engine_tb_top

// file: bench/tvae_host.sv
// Host model: AXI4-Lite master that issues register commands
`timescale 1ns/1ps
module tvae_host (
    input  wire logic        clock_in,
    output logic [7:0]       awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [7:0]       araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, araddr_out, arvalid_out} = '0;
        {bready_out, rready_out} = 2'h3;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        @(posedge clock_in);
        awaddr_out  <= a;
        wdata_out   <= d;
        awvalid_out <= 1'b1;
        wvalid_out  <= 1'b1;
        do begin
            @(negedge clock_in);
            ta   = awvalid_out & awready_in;
            tw   = wvalid_out & wready_in;
            done = bvalid_in;
            @(posedge clock_in);
            if (ta) awvalid_out <= 1'b0;
            if (tw) wvalid_out <= 1'b0;
        end while (!done);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        @(posedge clock_in);
        araddr_out  <= a;
        arvalid_out <= 1'b1;
        do begin
            @(negedge clock_in);
            ta   = arvalid_out & arready_in;
            done = rvalid_in;
            d    = rdata_in;
            r    = rresp_in;
            @(posedge clock_in);
            if (ta) arvalid_out <= 1'b0;
        end while (!done);
    endtask
endmodule // tvae_host

// file: core/tvae_engine.sv
// Velocity settings and arc generator with AXI4-Lite register access
// Notes on behaviour
// - Arc cruises at vector top speed
// - Acceleration ramps tangential speed only
// - Radius from 1/128 to 131,072 steps
// - Oversize radius runs straight to end point
// - Per tick, step target minus current position
// - Target recomputed 128 times per second
// - X acceleration rate also shapes arc speed
// - Parameter commands never start motion
// - Base speed 0 to 16,383.75, quarter steps
// - Maximum 0.25 to 16,383.75; zero rejected
// - Missing base or maximum keeps stored value
// - Decimal speeds round to nearest quarter step
// - Hex speeds stored raw, LSB quarter step
// - Axis steps derived from direction vector
// - Vector speeds share axis range, resolution
// - Vector speeds only for interpolated moves
// - Arcs force linear ramp, profile kept
`timescale 1ns/1ps
module tvae_engine #(
    parameter int TICK_CYCLES = tvae_pkg::TICK_CYCLES
) (
    input  wire logic                clock_in,
    input  wire logic                rst_n_in,
    input  wire logic [7:0]          s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic [7:0]          s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    output tvae_pkg::tvae_vel_t      x_axis_speed_out,
    output tvae_pkg::tvae_vel_t      y_axis_speed_out,
    output tvae_pkg::tvae_vel_t      vector_speed_out,
    output logic [4:0]               accel_profile_out,
    output logic                     arc_busy_out,
    output logic signed [31:0]       step_dx_out,
    output logic signed [31:0]       step_dy_out,
    output logic                     step_valid_out
);
    tvae_pkg::tvae_vel_t   x_vel_q, y_vel_q, v_vel_q, arc_vel_q;
    tvae_pkg::tvae_state_t state_q;
    logic [7:0]         aw_addr_q, ar_addr_q;
    logic               aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [31:0]        w_data_q, rdata_q;
    logic [3:0]         w_strb_q;
    logic [1:0]         rresp_q;
    logic [31:0]        vbase_in_q, vector_top_speed_in_q, rad_q, len_q, end_x_q, end_y_q;
    logic [15:0]        accel_q, speed_q;
    logic [4:0]         profile_q;
    logic signed [17:0] ux_q, uy_q;
    logic               cmd_bad_q, arc_err_q, straight_q;
    logic [31:0]        tick_cnt_q;
    logic [4:0]         div_cnt_q;
    logic [29:0]        div_num_q, div_quo_q;
    logic [30:0]        div_rem_q;
    logic signed [47:0] pos_x_q, pos_y_q;
    logic [47:0]        dist_q, ramp_q;
    logic               wr_go, cmd_go, cmd_bad, start_go;
    logic [31:0]        wr_val;
    logic [15:0]        new_base, new_top;
    logic               base_bad, top_bad;
    logic               tick;

    // Merge a write with byte enables
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] dat,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Convert an entered speed to quarter steps; bit 16 flags out of range
    function automatic logic [16:0] to_quarter(input logic [31:0] v, input logic dec);
        logic [32:0] s;
        s = {1'b0, v} + {1'b0, tvae_pkg::DEC_HALF};
        if (dec) begin
            to_quarter = {|s[32:tvae_pkg::DEC_SHIFT+16], s[tvae_pkg::DEC_SHIFT +: 16]};
        end else begin
            to_quarter = {|v[31:16], v[15:0]};
        end
    endfunction

    // AXI write channels, accepted in either order
    assign s_axi_awready_out = !aw_full_q;
    assign s_axi_wready_out  = !w_full_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = 2'h0;
    assign wr_go  = aw_full_q && w_full_q && !bvalid_q;
    assign wr_val = strb_merge(32'h0000_0000, w_data_q, w_strb_q);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_full_q) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q  <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
            end
        end
    end

    // Velocity command decode
    assign cmd_go   = wr_go && aw_addr_q == tvae_pkg::OFS_VCMD;
    assign start_go = wr_go && aw_addr_q == tvae_pkg::OFS_ARC_CTRL && wr_val[0] && state_q == tvae_pkg::ST_IDLE;
    always_comb begin
        logic [16:0] b, m;
        b = to_quarter(vbase_in_q, wr_val[tvae_pkg::VCMD_DEC]);
        m = to_quarter(vector_top_speed_in_q, wr_val[tvae_pkg::VCMD_DEC]);
        new_base = b[15:0];
        new_top  = m[15:0];
        base_bad = wr_val[tvae_pkg::VCMD_BASE] && b[16];
        top_bad  = wr_val[tvae_pkg::VCMD_MAX] && (m[16] || m[15:0] == 16'h0000);
        cmd_bad  = base_bad || top_bad || wr_val[1:0] == 2'h3;
    end

    // Stored speeds; a bad command changes no speed, only sets the error flag
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            x_vel_q   <= '{top: tvae_pkg::MAX_RST, base: tvae_pkg::BASE_RST};
            y_vel_q   <= '{top: tvae_pkg::MAX_RST, base: tvae_pkg::BASE_RST};
            v_vel_q   <= '{top: tvae_pkg::MAX_RST, base: tvae_pkg::BASE_RST};
            cmd_bad_q <= 1'b0;
        end else if (cmd_go) begin
            cmd_bad_q <= cmd_bad;
            if (!cmd_bad) begin
                unique case (wr_val[1:0])
                    tvae_pkg::TGT_X: begin
                        if (wr_val[tvae_pkg::VCMD_BASE]) x_vel_q.base <= new_base;
                        if (wr_val[tvae_pkg::VCMD_MAX])  x_vel_q.top  <= new_top;
                    end
                    tvae_pkg::TGT_Y: begin
                        if (wr_val[tvae_pkg::VCMD_BASE]) y_vel_q.base <= new_base;
                        if (wr_val[tvae_pkg::VCMD_MAX])  y_vel_q.top  <= new_top;
                    end
                    default: begin
                        if (wr_val[tvae_pkg::VCMD_BASE]) v_vel_q.base <= new_base;
                        if (wr_val[tvae_pkg::VCMD_MAX])  v_vel_q.top  <= new_top;
                    end
                endcase
            end
        end
    end

    // Plain settings registers; writing them never moves anything
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            vbase_in_q <= 32'h0000_0000;
            vector_top_speed_in_q  <= 32'h0000_0000;
            accel_q    <= tvae_pkg::ACCEL_RST;
            profile_q  <= tvae_pkg::PROF_LINEAR;
            rad_q      <= 32'h0000_0000;
            len_q      <= 32'h0000_0000;
            end_x_q    <= 32'h0000_0000;
            end_y_q    <= 32'h0000_0000;
        end else if (wr_go) begin
            unique case (aw_addr_q)
                tvae_pkg::OFS_VBASE_IN: vbase_in_q <= strb_merge(vbase_in_q, w_data_q, w_strb_q);
                tvae_pkg::OFS_VECTOR_TOP_SPEED_IN:  vector_top_speed_in_q  <= strb_merge(vector_top_speed_in_q, w_data_q, w_strb_q);
                tvae_pkg::OFS_X_ACCEL:  accel_q    <= wr_val[15:0] == 16'h0000 ? accel_q : wr_val[15:0];
                tvae_pkg::OFS_PROFILE:  profile_q  <= wr_val[4:0];
                tvae_pkg::OFS_ARC_RAD:  rad_q      <= strb_merge(rad_q, w_data_q, w_strb_q);
                tvae_pkg::OFS_ARC_LEN:  len_q      <= strb_merge(len_q, w_data_q, w_strb_q);
                tvae_pkg::OFS_END_X:    end_x_q    <= strb_merge(end_x_q, w_data_q, w_strb_q);
                tvae_pkg::OFS_END_Y:    end_y_q    <= strb_merge(end_y_q, w_data_q, w_strb_q);
                default: ;
            endcase
        end
    end

    // Update tick at 128 Hz while an arc runs
    assign tick = tick_cnt_q == TICK_CYCLES - 1;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || state_q == tvae_pkg::ST_IDLE || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // Turn rate per tick, Q16 radians: speed / radius, by long division
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            div_cnt_q <= 5'h00;
            div_num_q <= 30'h0000_0000;
            div_quo_q <= 30'h0000_0000;
            div_rem_q <= 31'h0000_0000;
        end else if (state_q == tvae_pkg::ST_WAIT && tick) begin
            div_cnt_q <= 5'(tvae_pkg::DIV_STEPS);
            div_num_q <= {speed_q, 14'h0000};
            div_rem_q <= 31'h0000_0000;
        end else if (div_cnt_q != 5'h00) begin
            logic [30:0] t;
            t = {div_rem_q[29:0], div_num_q[29]};
            div_num_q <= {div_num_q[28:0], 1'b0};
            div_cnt_q <= div_cnt_q - 5'h01;
            if (t >= {6'h00, rad_q[24:0]}) begin
                div_rem_q <= t - {6'h00, rad_q[24:0]};
                div_quo_q <= {div_quo_q[28:0], 1'b1};
            end else begin
                div_rem_q <= t;
                div_quo_q <= {div_quo_q[28:0], 1'b0};
            end
        end
    end

    // Arc stepping
    logic [16:0]        rate;
    logic [22:0]        seg;
    logic signed [17:0] ux_n, uy_n;
    logic signed [47:0] px_n, py_n;
    logic [17:0]        up, dn;
    logic               decel, done;
    logic [15:0]        spd_floor;
    always_comb begin
        logic signed [35:0] p1, p2;
        logic signed [41:0] mx, my;
        rate = straight_q ? 17'h00000 : (|div_quo_q[29:17] ? tvae_pkg::RATE_CLAMP : div_quo_q[16:0]);
        p1   = $signed({1'b0, rate}) * uy_q;
        ux_n = ux_q - 18'(p1 >>> 16);
        p2   = $signed({1'b0, rate}) * ux_n;
        uy_n = uy_q + 18'(p2 >>> 16);
        seg  = {speed_q, 7'h00};
        mx   = $signed({1'b0, seg}) * ux_q;
        my   = $signed({1'b0, seg}) * uy_q;
        px_n = pos_x_q + 48'(mx >>> 15);
        py_n = pos_y_q + 48'(my >>> 15);
        up   = {2'b00, speed_q} + {1'b0, accel_q, 1'b0};
        dn   = {2'b00, speed_q} - {1'b0, accel_q, 1'b0};
        spd_floor = arc_vel_q.base > arc_vel_q.top ? arc_vel_q.top : arc_vel_q.base;
        done  = dist_q + {25'h0, seg} >= {len_q, 16'h0000};
        decel = {len_q, 16'h0000} - dist_q <= ramp_q;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q    <= tvae_pkg::ST_IDLE;
            speed_q    <= 16'h0000;
            ux_q       <= 18'h00000;
            uy_q       <= 18'h00000;
            pos_x_q    <= 48'sh0;
            pos_y_q    <= 48'sh0;
            dist_q     <= 48'h0;
            ramp_q     <= 48'h0;
            straight_q <= 1'b0;
            arc_err_q  <= 1'b0;
            arc_vel_q  <= '{top: tvae_pkg::MAX_RST, base: tvae_pkg::BASE_RST};
        end else begin
            unique case (state_q)
                tvae_pkg::ST_IDLE: begin
                    if (start_go) begin
                        arc_err_q <= rad_q < tvae_pkg::RAD_MIN;
                        if (rad_q >= tvae_pkg::RAD_MIN) begin
                            state_q    <= tvae_pkg::ST_WAIT;
                            straight_q <= rad_q > tvae_pkg::RAD_MAX;
                            ux_q       <= 18'(signed'(wr_val[31:16]));
                            uy_q       <= 18'(signed'(wr_val[15:0]));
                            speed_q    <= v_vel_q.base > v_vel_q.top ? v_vel_q.top : v_vel_q.base;
                            arc_vel_q  <= v_vel_q;
                            dist_q     <= 48'h0;
                            ramp_q     <= 48'h0;
                        end
                    end
                end
                tvae_pkg::ST_WAIT: if (tick) state_q <= tvae_pkg::ST_DIV;
                tvae_pkg::ST_DIV:  if (div_cnt_q == 5'h01) state_q <= tvae_pkg::ST_APPLY;
                default: begin
                    state_q <= done ? tvae_pkg::ST_IDLE : tvae_pkg::ST_WAIT;
                    ux_q    <= ux_n;
                    uy_q    <= uy_n;
                    dist_q  <= dist_q + {25'h0, seg};
                    if (done) begin
                        pos_x_q <= {end_x_q, 16'h0000};
                        pos_y_q <= {end_y_q, 16'h0000};
                        speed_q <= 16'h0000;
                    end else begin
                        pos_x_q <= px_n;
                        pos_y_q <= py_n;
                        if (decel) begin
                            speed_q <= dn[17] || dn[15:0] < spd_floor ? spd_floor : dn[15:0];
                        end else if (up[15:0] >= arc_vel_q.top || |up[17:16]) begin
                            speed_q <= arc_vel_q.top;
                        end else begin
                            speed_q <= up[15:0];
                            ramp_q  <= ramp_q + {25'h0, seg};
                        end
                    end
                end
            endcase
        end
    end

    // Step increments per tick, from integer parts of target and current position
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            step_dx_out    <= 32'sh0;
            step_dy_out    <= 32'sh0;
            step_valid_out <= 1'b0;
        end else begin
            step_valid_out <= state_q == tvae_pkg::ST_APPLY;
            if (state_q == tvae_pkg::ST_APPLY) begin
                step_dx_out <= (done ? end_x_q : px_n[47:16]) - pos_x_q[47:16];
                step_dy_out <= (done ? end_y_q : py_n[47:16]) - pos_y_q[47:16];
            end
        end
    end

    // Read channel
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= 2'h0;
            unique case (s_axi_araddr_in)
                tvae_pkg::OFS_VBASE_IN: rdata_q <= vbase_in_q;
                tvae_pkg::OFS_VECTOR_TOP_SPEED_IN:  rdata_q <= vector_top_speed_in_q;
                tvae_pkg::OFS_X_VEL:    rdata_q <= x_vel_q;
                tvae_pkg::OFS_Y_VEL:    rdata_q <= y_vel_q;
                tvae_pkg::OFS_V_VEL:    rdata_q <= v_vel_q;
                tvae_pkg::OFS_X_ACCEL:  rdata_q <= {16'h0000, accel_q};
                tvae_pkg::OFS_PROFILE:  rdata_q <= {27'h0, profile_q};
                tvae_pkg::OFS_ARC_UX:   rdata_q <= 32'(ux_q);
                tvae_pkg::OFS_ARC_UY:   rdata_q <= 32'(uy_q);
                tvae_pkg::OFS_ARC_RAD:  rdata_q <= rad_q;
                tvae_pkg::OFS_ARC_LEN:  rdata_q <= len_q;
                tvae_pkg::OFS_END_X:    rdata_q <= end_x_q;
                tvae_pkg::OFS_END_Y:    rdata_q <= end_y_q;
                tvae_pkg::OFS_STATUS:   rdata_q <= {28'h0, straight_q, arc_err_q, cmd_bad_q, arc_busy_out};
                tvae_pkg::OFS_POS_X:    rdata_q <= pos_x_q[47:16];
                tvae_pkg::OFS_POS_Y:    rdata_q <= pos_y_q[47:16];
                tvae_pkg::OFS_SPEED:    rdata_q <= {16'h0000, speed_q};
                tvae_pkg::OFS_VCMD, tvae_pkg::OFS_ARC_CTRL: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'h2;
                end
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    assign x_axis_speed_out  = x_vel_q;
    assign y_axis_speed_out  = y_vel_q;
    assign vector_speed_out  = v_vel_q;
    assign arc_busy_out      = state_q != tvae_pkg::ST_IDLE;
    assign accel_profile_out = arc_busy_out ? tvae_pkg::PROF_LINEAR : profile_q;

    a_reject_keeps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cmd_go && cmd_bad |=> $stable(x_vel_q) && $stable(y_vel_q) && $stable(v_vel_q))
        else $error("rejected command changed a speed");
    a_top_nonzero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        x_vel_q.top != 16'h0000 && y_vel_q.top != 16'h0000 && v_vel_q.top != 16'h0000)
        else $error("stored top speed is zero");
    a_hex_direct: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cmd_go && !cmd_bad && !wr_val[4] && wr_val[2] && wr_val[1:0] == 2'h0
        |=> x_vel_q.base == $past(vbase_in_q[15:0]))
        else $error("hex base not stored raw");
    a_no_start: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cmd_go && !arc_busy_out |=> !arc_busy_out)
        else $error("speed command started motion");
    a_div_time: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        state_q == tvae_pkg::ST_WAIT && tick |=> ##30 state_q == tvae_pkg::ST_APPLY)
        else $error("update not applied in time");
    a_speed_cap: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        arc_busy_out |-> speed_q <= arc_vel_q.top)
        else $error("arc speed above top speed");
    a_profile_lin: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        arc_busy_out |-> accel_profile_out == tvae_pkg::PROF_LINEAR)
        else $error("arc not on linear ramp");
    a_straight_dir: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        state_q == tvae_pkg::ST_APPLY && straight_q |=> $stable(ux_q) && $stable(uy_q))
        else $error("straight move turned");
    a_step_delta: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        state_q == tvae_pkg::ST_APPLY |=> step_valid_out
        && step_dx_out == pos_x_q[47:16] - $past(pos_x_q[47:16]))
        else $error("step delta mismatch");
endmodule // tvae_engine

// file: core/tvae_pkg.sv
// Package of constants and types for the two-axis velocity and arc engine
package tvae_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_VCMD     = 8'h00;
    localparam logic [7:0] OFS_VBASE_IN = 8'h04;
    localparam logic [7:0] OFS_VECTOR_TOP_SPEED_IN  = 8'h08;
    localparam logic [7:0] OFS_X_VEL    = 8'h0c;
    localparam logic [7:0] OFS_Y_VEL    = 8'h10;
    localparam logic [7:0] OFS_V_VEL    = 8'h14;
    localparam logic [7:0] OFS_X_ACCEL  = 8'h18;
    localparam logic [7:0] OFS_PROFILE  = 8'h1c;
    localparam logic [7:0] OFS_ARC_UX   = 8'h20;
    localparam logic [7:0] OFS_ARC_UY   = 8'h24;
    localparam logic [7:0] OFS_ARC_RAD  = 8'h28;
    localparam logic [7:0] OFS_ARC_LEN  = 8'h2c;
    localparam logic [7:0] OFS_END_X    = 8'h30;
    localparam logic [7:0] OFS_END_Y    = 8'h34;
    localparam logic [7:0] OFS_ARC_CTRL = 8'h38;
    localparam logic [7:0] OFS_STATUS   = 8'h3c;
    localparam logic [7:0] OFS_POS_X    = 8'h40;
    localparam logic [7:0] OFS_POS_Y    = 8'h44;
    localparam logic [7:0] OFS_SPEED    = 8'h48;
    // Velocity command fields
    localparam int VCMD_TGT_LO = 0;
    localparam int VCMD_BASE   = 2;
    localparam int VCMD_MAX    = 3;
    localparam int VCMD_DEC    = 4;
    localparam logic [1:0] TGT_X   = 2'h0;
    localparam logic [1:0] TGT_Y   = 2'h1;
    localparam logic [1:0] TGT_VEC = 2'h2;
    // Decimal entry has 8 fraction bits; a quarter step is 64 of their LSBs
    localparam int DEC_SHIFT = 6;
    localparam logic [31:0] DEC_HALF = 32'h0000_0020;
    // Reset values
    localparam logic [15:0] BASE_RST  = 16'h0000;
    localparam logic [15:0] MAX_RST   = 16'h0001;
    localparam logic [15:0] ACCEL_RST = 16'h0001;
    localparam logic [4:0]  PROF_LINEAR = 5'h00;
    // Radius in 1/128 step: 1/128 up to 131,072 steps
    localparam logic [31:0] RAD_MIN = 32'h0000_0001;
    localparam logic [31:0] RAD_MAX = 32'h0100_0000;
    // Arc update rate
    localparam int CLK_HZ  = 50_000_000;
    localparam int TICK_HZ = 128;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int DIV_STEPS = 30;
    localparam logic [16:0] RATE_CLAMP = 17'h1ffff;
    typedef struct packed {
        logic [15:0] top;
        logic [15:0] base;
    } tvae_vel_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DIV, ST_APPLY} tvae_state_t;
endpackage
